// File: dv/hecl_eeprom_model.sv
// model: serial configuration memory answering the read command
`timescale 1ns/1ps
module hecl_eeprom_model (
	input wire logic spi_cs_n,
	input wire logic spi_sck,
	input wire logic spi_mosi,
	output logic spi_miso
);
	logic [7:0] image [0:31];
	logic [7:0] cmd_seen;
	logic [15:0] addr;
	int nbits;
	int k;
	initial spi_miso = 1'b0;
	// a new frame restarts the bit count
	always @(negedge spi_cs_n)
		nbits = 0;
	// command and address are sampled on the rising edge, msb first
	always @(posedge spi_sck)
	begin
		if (!spi_cs_n)
		begin
			if (nbits < 8)
				cmd_seen = {cmd_seen[6:0], spi_mosi};
			else if (nbits < 24)
				addr = {addr[14:0], spi_mosi};
			nbits++;
		end
	end
	// data leaves on the falling edge so it is settled before the next rising edge
	always @(negedge spi_sck)
	begin
		if (!spi_cs_n && nbits >= 24)
		begin
			k = nbits - 24;
			spi_miso = image[(int'(addr) + k / 8) % 32][7 - k % 8];
		end
		else
			spi_miso = ~spi_miso; // undriven during command bytes: never a stale bit
	end
	// a released line keeps no value: show the inverse of the last bit
	always @(posedge spi_cs_n)
		spi_miso = ~spi_miso;
endmodule // hecl_eeprom_model

// File: dv/hecl_loader_properties.sv
// checker: concurrent properties on the loader's ports
`timescale 1ns/1ps
module hecl_loader_chk
	import hecl_pkg::*;
#(
	parameter int MS_CYCLES = 20
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic spi_cs_n,
	input wire logic spi_sck,
	input wire logic spi_mosi,
	input wire logic port_enabled,
	input wire logic oc_raw,
	input wire logic oc_qualified,
	input wire logic config_valid,
	input wire logic [15:0] vendor_id,
	input wire logic [15:0] product_id,
	input wire logic [3:0] enabled_port_oc_filter_ms,
	input wire logic [3:0] disabled_port_oc_filter_ms,
	input wire logic [7:0] port_power_good_delay,
	input wire logic [7:0] language_count,
	input wire logic strings_enabled
);
	logic [11:0] oc_cnt_reg;
	logic [11:0] oc_cnt_next;
	int oc_lim;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// cycles the raw overcurrent has persisted; 15 ms of sim cycles fit easily
	always_comb oc_cnt_next = oc_raw ? oc_cnt_reg + 12'h001 : 12'h000;
	always_ff @(posedge ref_clk) oc_cnt_reg <= rst ? 12'h000 : oc_cnt_next;
	assign oc_lim = int'(port_enabled ? enabled_port_oc_filter_ms
		: disabled_port_oc_filter_ms) * MS_CYCLES;
	// ----------------------------------------
	// properties
	// ----------------------------------------
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus slave stalled or answered an error");
	chk_reset_defaults: assert property ($past(rst) |-> vendor_id == HECL_DEF_VID
		&& product_id == HECL_DEF_PID && port_power_good_delay == HECL_DEF_PG
		&& !config_valid && !strings_enabled)
		else $error("fields not at defaults after reset");
	chk_load_start: assert property ($fell(rst) |-> ##[0:3] !spi_cs_n)
		else $error("no load started after reset");
	chk_burst_hold: assert property ($fell(spi_cs_n) |-> !spi_cs_n [*8])
		else $error("chip select dropped inside a burst");
	chk_sck_idle: assert property (spi_cs_n |-> !spi_sck)
		else $error("serial clock not idle low");
	chk_mosi_setup: assert property ($rose(spi_sck) |-> $stable(spi_mosi))
		else $error("serial data moved at the sampling edge");
	chk_strings_range: assert property (strings_enabled |-> language_count != 8'h00
		&& language_count <= HECL_MAX_LANGS)
		else $error("strings enabled with a bad language count");
	chk_oc_clear: assert property (!oc_raw |=> !oc_qualified)
		else $error("qualified overcurrent outlived the raw input");
	chk_oc_timing: assert property ($rose(oc_qualified) |->
		int'(oc_cnt_reg) + MS_CYCLES > oc_lim && int'(oc_cnt_reg) <= oc_lim + 3)
		else $error("overcurrent qualified at the wrong persistence");
endmodule // hecl_loader_chk

bind hecl_loader hecl_loader_chk #(.MS_CYCLES(MS_CYCLES)) i_chk (.ref_clk(ref_clk), .rst(rst),
	.hreadyout(hreadyout), .hresp(hresp), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
	.spi_mosi(spi_mosi), .port_enabled(port_enabled), .oc_raw(oc_raw),
	.oc_qualified(oc_qualified), .config_valid(config_valid), .vendor_id(vendor_id),
	.product_id(product_id), .enabled_port_oc_filter_ms(enabled_port_oc_filter_ms),
	.disabled_port_oc_filter_ms(disabled_port_oc_filter_ms),
	.port_power_good_delay(port_power_good_delay), .language_count(language_count),
	.strings_enabled(strings_enabled));

// File: dv/testbench.sv
// testbench: bus-driven checks of the configuration loader against a memory model
`timescale 1ns/1ps
module testbench;
	import hecl_pkg::*;
	localparam int MSC = 20;
	localparam logic [7:0] IMG [0:20] = '{8'h5a, 8'hcd, 8'hab, 8'h12, 8'h34, 8'hff, 8'h9c,
		8'h3a, 8'h11, 8'h22, 8'h00, 8'h00, 8'h33, 8'h44, 8'h00, 8'h00, 8'h55, 8'h00, 8'h00,
		8'h00, 8'h03}; // signature first, reserved bytes zero
	logic ref_clk, rst, hsel, hwrite, hreadyout, port_enabled, oc_raw, oc_qualified;
	logic spi_cs_n, spi_sck, spi_mosi, spi_miso, config_valid, strings_enabled;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [15:0] vendor_id, product_id;
	logic [7:0] release_id_hi, ub_fs, ub_hs, cd_fs, cd_hs, pg_delay;
	logic [3:0] en_ms, dis_ms;
	logic [7:0] language_count;
	logic [7:0] lcs [3] = '{8'h00, 8'h1f, 8'h20};
	int n_errors, check_count;
	hecl_loader #(.MS_CYCLES(MSC), .SPI_HALF(1)) i_dut (.ref_clk(ref_clk), .rst(rst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
		.spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.port_enabled(port_enabled), .oc_raw(oc_raw), .oc_qualified(oc_qualified),
		.config_valid(config_valid), .vendor_id(vendor_id), .product_id(product_id),
		.release_id_hi(release_id_hi), .enabled_port_oc_filter_ms(en_ms),
		.disabled_port_oc_filter_ms(dis_ms), .upstream_current_budget_fs(ub_fs),
		.upstream_current_budget_hs(ub_hs), .controller_current_draw_fs(cd_fs),
		.controller_current_draw_hs(cd_hs), .port_power_good_delay(pg_delay),
		.language_count(language_count),
		.strings_enabled(strings_enabled));
	hecl_eeprom_model i_mem (.spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one single-word transfer; read data is taken at the edge that ends the data phase
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic reg_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		xfer({24'h0, a}, 1'b0, 32'h0);
		check(what, exp, rd);
	endtask
	// poll the busy flag; the bound only guards against a stuck loader
	task automatic wait_load();
		repeat (4) @(posedge ref_clk);
		rd = 32'h2;
		for (int i = 0; i < 400 && rd[1] !== 1'b0; i++)
			xfer({24'h0, HECL_REG_STATUS}, 1'b0, 32'h0);
		check("load finished", 32'h0, {31'h0, rd[1]});
	endtask
	task automatic reload(input logic [7:0] sig, input logic [7:0] lc);
		i_mem.image[0] = sig;
		i_mem.image[20] = lc;
		xfer({24'h0, HECL_REG_CTRL}, 1'b1, 32'h5); // keep the filter enabled while reloading
		wait_load();
	endtask
	task automatic oc_run(input logic pe, input int nib);
		@(posedge ref_clk);
		port_enabled <= pe;
		oc_raw <= 1'b1;
		repeat (nib * MSC - MSC - 2) @(posedge ref_clk);
		check("oc_qualified early", 32'h0, oc_qualified);
		repeat (MSC + 7) @(posedge ref_clk);
		check("oc_qualified late", 32'h1, oc_qualified);
		oc_raw <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check("oc_qualified clear", 32'h0, oc_qualified);
	endtask
	task automatic give_verdict();
		if (n_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// clock, watchdog and sequence
	// ----------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// six loads of a few hundred cycles each fit well inside this span
	initial
	begin
		repeat (30000) @(posedge ref_clk);
		n_errors++;
		give_verdict();
	end
	initial
	begin
		{rst, hsel, hwrite, port_enabled, oc_raw} = 5'b10000;
		{haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'b010};
		for (int i = 0; i < 32; i++)
			i_mem.image[i] = (i < 21) ? IMG[i] : 8'h00;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		wait_load();
		check("read command", 32'h3, i_mem.cmd_seen);
		check("id pins", 32'h3412abcd, {product_id, vendor_id});
		check("dev pins", 32'h553a9c, {pg_delay, en_ms, dis_ms, release_id_hi});
		check("power pins", 32'h44332211, {cd_hs, cd_fs, ub_hs, ub_fs});
		reg_chk("ids", HECL_REG_IDS, 32'h3412abcd);
		reg_chk("dev", HECL_REG_DEV, 32'h00553a9c);
		reg_chk("power", HECL_REG_POWER, 32'h44332211);
		reg_chk("strings", HECL_REG_STRINGS, 32'h0060_1e03);
		reg_chk("status", HECL_REG_STATUS, 32'h1c);
		xfer(32'h40, 1'b1, 32'hffffffff);
		reg_chk("unmapped", 8'h40, 32'h0);
		oc_run(1'b1, 3);
		oc_run(1'b0, 10);
		foreach (lcs[i])
		begin
			reload(8'h5a, lcs[i]);
			check("language_count", {24'h0, lcs[i]}, language_count);
			check("strings_enabled", {31'h0, lcs[i] == 8'h1f}, strings_enabled);
		end
		reload(8'ha5, 8'h03);
		check("config_valid", 32'h0, config_valid);
		reg_chk("ids default", HECL_REG_IDS, {HECL_DEF_PID, HECL_DEF_VID});
		reg_chk("dev default", HECL_REG_DEV, 32'h00328801);
		reg_chk("power default", HECL_REG_POWER, 32'hae505728);
		check("strings default", 32'h0, strings_enabled);
		check("power pins default", 32'hae505728, {cd_hs, cd_fs, ub_hs, ub_fs});
		// forced defaults with a good image, filter switched off by the same write
		i_mem.image[0] = 8'h5a;
		xfer({24'h0, HECL_REG_CTRL}, 1'b1, 32'h3);
		wait_load();
		reg_chk("status forced", HECL_REG_STATUS, 32'h0);
		oc_raw <= 1'b1;
		repeat (9 * MSC) @(posedge ref_clk);
		check("oc filter off", 32'h0, oc_qualified);
		oc_raw <= 1'b0;
		give_verdict();
	end
endmodule // testbench

// File: verilog/hecl_loader.sv
// module: hub configuration loader, serial memory reader and register slave
// Behaviour
// - vendor id from bytes one, two
// - product id from bytes three, four
// - release high byte six, byte five ignored
// - byte seven splits enabled/disabled filter nibbles
// - overcurrent qualified after persisting nibble milliseconds
// - byte eight is full-speed current budget
// - byte nine is high-speed current budget
// - byte twelve is full-speed controller draw
// - byte thirteen is high-speed controller draw
// - byte sixteen is power-good delay
// - pointer tables step by twice language count
// - bad language count disables all strings
//
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module hecl_loader #(
	parameter int MS_CYCLES = hecl_pkg::HECL_MS_CYCLES,
	parameter int SPI_HALF = hecl_pkg::HECL_SPI_HALF_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic spi_cs_n,
	output logic spi_sck,
	output logic spi_mosi,
	input wire logic spi_miso,
	input wire logic port_enabled,
	input wire logic oc_raw,
	output logic oc_qualified,
	output logic config_valid,
	output logic [15:0] vendor_id,
	output logic [15:0] product_id,
	output logic [7:0] release_id_hi,
	output logic [3:0] enabled_port_oc_filter_ms,
	output logic [3:0] disabled_port_oc_filter_ms,
	output logic [7:0] upstream_current_budget_fs,
	output logic [7:0] upstream_current_budget_hs,
	output logic [7:0] controller_current_draw_fs,
	output logic [7:0] controller_current_draw_hs,
	output logic [7:0] port_power_good_delay,
	output logic [7:0] language_count,
	output logic strings_enabled
);
	import hecl_pkg::*;

	// refused at elaboration: the dividers are 24 and 16 bits wide
	if (MS_CYCLES < 1 || MS_CYCLES > 16777215 || SPI_HALF < 1 || SPI_HALF > 65535)
	begin : g_bad_timing
		$error("timing parameter out of range");
	end

	//--------------------------------------------------------------
	// serial memory loader
	//--------------------------------------------------------------
	hecl_state_type state_reg, state_next;
	logic [7:0] image_reg [0:20];
	logic [7:0] image_next [0:20];
	logic [4:0] idx_reg, idx_next;
	logic wait_reg, wait_next;
	logic loaded_reg, loaded_next;
	logic spi_start, spi_busy, spi_done;
	logic [7:0] spi_tx, spi_rx;
	logic reload_req;
	logic force_def_reg;

	hecl_spi_byte #(
		.HALF_CYCLES(SPI_HALF)
	) u_spi (
		.ref_clk(ref_clk),
		.rst(rst),
		.start(spi_start),
		.tx_byte(spi_tx),
		.miso(spi_miso),
		.sck(spi_sck),
		.mosi(spi_mosi),
		.busy(spi_busy),
		.done(spi_done),
		.rx_byte(spi_rx)
	);

	// one byte at a time: issue, wait for done, advance
	always_comb
	begin
		state_next = state_reg;
		idx_next = idx_reg;
		wait_next = wait_reg;
		loaded_next = 1'b0;
		image_next = image_reg;
		spi_start = 1'b0;
		spi_tx = 8'h00;
		unique case (state_reg)
			HECL_IDLE:
			begin
				if (reload_req)
				begin
					state_next = HECL_CMD;
					wait_next = 1'b0;
				end
			end
			HECL_CMD, HECL_ADDR_HI, HECL_ADDR_LO, HECL_READ:
			begin
				unique case (state_reg)
					HECL_CMD: spi_tx = HECL_CMD_READ;
					HECL_ADDR_HI: spi_tx = HECL_START_ADDR[15:8];
					HECL_ADDR_LO: spi_tx = HECL_START_ADDR[7:0];
					default: spi_tx = 8'h00;
				endcase
				if (!wait_reg && !spi_busy)
				begin
					spi_start = 1'b1;
					wait_next = 1'b1;
				end
				else if (spi_done)
				begin
					wait_next = 1'b0;
					unique case (state_reg)
						HECL_CMD: state_next = HECL_ADDR_HI;
						HECL_ADDR_HI: state_next = HECL_ADDR_LO;
						HECL_ADDR_LO:
						begin
							state_next = HECL_READ;
							idx_next = 5'h00;
						end
						default:
						begin
							image_next[idx_reg] = spi_rx;
							idx_next = idx_reg + 5'h01;
							if (idx_reg == HECL_LOAD_BYTES - 5'h01)
								state_next = HECL_DONE;
						end
					endcase
				end
			end
			HECL_DONE:
			begin
				loaded_next = 1'b1;
				state_next = HECL_IDLE;
			end
			default: state_next = HECL_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_reg <= HECL_IDLE;
			idx_reg <= 5'h00;
			wait_reg <= 1'b0;
			loaded_reg <= 1'b0;
			for (int i = 0; i < 21; i++)
				image_reg[i] <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			idx_reg <= idx_next;
			wait_reg <= wait_next;
			loaded_reg <= loaded_next;
			image_reg <= image_next;
		end
	end

	// chip select spans the whole read burst
	assign spi_cs_n = (state_reg == HECL_IDLE) || (state_reg == HECL_DONE);

	//--------------------------------------------------------------
	// decode of the loaded image
	//--------------------------------------------------------------
	logic sig_ok;
	logic [7:0] lang_raw;
	logic [7:0] oc_byte;
	logic [15:0] vid_reg, vid_next, pid_reg, pid_next;
	logic [7:0] did_reg, did_next, oc_reg, oc_next, mpfs_reg, mpfs_next;
	logic [7:0] mphs_reg, mphs_next, hcfs_reg, hcfs_next, hchs_reg, hchs_next;
	logic [7:0] pg_reg, pg_next, lang_reg, lang_next;
	logic str_reg, str_next, valid_reg, valid_next;

	// a forced-default request behaves like a bad signature
	assign sig_ok = (image_reg[HECL_OFS_SIG] == HECL_SIGNATURE) && !force_def_reg;
	assign lang_raw = image_reg[HECL_OFS_LANG];

	always_comb
	begin
		vid_next = vid_reg;
		pid_next = pid_reg;
		did_next = did_reg;
		oc_next = oc_reg;
		mpfs_next = mpfs_reg;
		mphs_next = mphs_reg;
		hcfs_next = hcfs_reg;
		hchs_next = hchs_reg;
		pg_next = pg_reg;
		lang_next = lang_reg;
		str_next = str_reg;
		valid_next = valid_reg;
		if (loaded_reg && sig_ok)
		begin
			vid_next = {image_reg[HECL_OFS_VID_HI], image_reg[HECL_OFS_VID_LO]};
			pid_next = {image_reg[HECL_OFS_PID_HI], image_reg[HECL_OFS_PID_LO]};
			did_next = image_reg[HECL_OFS_DID_HI];
			oc_next = image_reg[HECL_OFS_OC];
			mpfs_next = image_reg[HECL_OFS_MP_FS];
			mphs_next = image_reg[HECL_OFS_MP_HS];
			hcfs_next = image_reg[HECL_OFS_HC_FS];
			hchs_next = image_reg[HECL_OFS_HC_HS];
			pg_next = image_reg[HECL_OFS_PG];
			lang_next = lang_raw;
			str_next = (lang_raw != 8'h00) && (lang_raw <= HECL_MAX_LANGS);
			valid_next = 1'b1;
		end
		else if (loaded_reg)
		begin
			// bytes ten, eleven, fourteen, fifteen are never looked at
			vid_next = HECL_DEF_VID;
			pid_next = HECL_DEF_PID;
			did_next = HECL_DEF_DID_HI;
			oc_next = HECL_DEF_OC;
			mpfs_next = HECL_DEF_MP_FS;
			mphs_next = HECL_DEF_MP_HS;
			hcfs_next = HECL_DEF_HC_FS;
			hchs_next = HECL_DEF_HC_HS;
			pg_next = HECL_DEF_PG;
			lang_next = HECL_DEF_LANG;
			str_next = 1'b0;
			valid_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			vid_reg <= HECL_DEF_VID;
			pid_reg <= HECL_DEF_PID;
			did_reg <= HECL_DEF_DID_HI;
			oc_reg <= HECL_DEF_OC;
			mpfs_reg <= HECL_DEF_MP_FS;
			mphs_reg <= HECL_DEF_MP_HS;
			hcfs_reg <= HECL_DEF_HC_FS;
			hchs_reg <= HECL_DEF_HC_HS;
			pg_reg <= HECL_DEF_PG;
			lang_reg <= HECL_DEF_LANG;
			str_reg <= 1'b0;
			valid_reg <= 1'b0;
		end
		else
		begin
			vid_reg <= vid_next;
			pid_reg <= pid_next;
			did_reg <= did_next;
			oc_reg <= oc_next;
			mpfs_reg <= mpfs_next;
			mphs_reg <= mphs_next;
			hcfs_reg <= hcfs_next;
			hchs_reg <= hchs_next;
			pg_reg <= pg_next;
			lang_reg <= lang_next;
			str_reg <= str_next;
			valid_reg <= valid_next;
		end
	end

	// first pointer table sits after the language ids; each later one adds 2N
	logic [9:0] ptr_base, ptr_stride;
	assign ptr_stride = {1'b0, lang_reg, 1'b0};
	assign ptr_base = HECL_LANG_ARRAY + ptr_stride;

	//--------------------------------------------------------------
	// overcurrent filter on a millisecond enable
	//--------------------------------------------------------------
	logic [23:0] ms_div_reg, ms_div_next;
	logic [3:0] oc_cnt_reg, oc_cnt_next;
	logic oc_q_reg, oc_q_next, oc_en_reg;
	logic [3:0] oc_limit;

	assign oc_byte = oc_reg;
	assign oc_limit = port_enabled ? oc_byte[7:4] : oc_byte[3:0];

	// the ms count restarts with each new indication, so qualification comes one cycle after the nibble's milliseconds
	always_comb
	begin
		ms_div_next = ms_div_reg + 24'h000001;
		oc_cnt_next = oc_cnt_reg;
		oc_q_next = oc_q_reg;
		if (!oc_raw || !oc_en_reg)
		begin
			ms_div_next = 24'h000000;
			oc_cnt_next = 4'h0;
			oc_q_next = 1'b0;
		end
		else if (oc_cnt_reg >= oc_limit)
			oc_q_next = 1'b1;
		else if (ms_div_reg == 24'(MS_CYCLES - 1))
		begin
			ms_div_next = 24'h000000;
			oc_cnt_next = oc_cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			ms_div_reg <= 24'h000000;
			oc_cnt_reg <= 4'h0;
			oc_q_reg <= 1'b0;
		end
		else
		begin
			ms_div_reg <= ms_div_next;
			oc_cnt_reg <= oc_cnt_next;
			oc_q_reg <= oc_q_next;
		end
	end

	//--------------------------------------------------------------
	// ahb-lite slave, zero wait states
	//--------------------------------------------------------------
	logic ph_wr_reg, ph_wr_next, ph_rd_reg, ph_rd_next;
	logic [7:0] ph_addr_reg, ph_addr_next;
	logic [31:0] rdata_reg, rdata_next;
	logic boot_reg, boot_next, force_def_next, oc_en_next;

	// the first cycle out of reset starts a load on its own
	assign reload_req = boot_reg
		|| (ph_wr_reg && ph_addr_reg == HECL_REG_CTRL && hwdata[HECL_CTRL_RELOAD]);

	always_comb
	begin
		ph_wr_next = 1'b0;
		ph_rd_next = 1'b0;
		ph_addr_next = ph_addr_reg;
		rdata_next = rdata_reg;
		boot_next = 1'b0;
		force_def_next = force_def_reg;
		oc_en_next = oc_en_reg;
		if (hsel && htrans[1] && hready)
		begin
			ph_wr_next = hwrite;
			ph_rd_next = !hwrite;
			ph_addr_next = {haddr[7:2], 2'b00};
		end
		if (ph_wr_reg && ph_addr_reg == HECL_REG_CTRL)
		begin
			force_def_next = hwdata[HECL_CTRL_FORCE_DEF];
			oc_en_next = hwdata[HECL_CTRL_OC_EN];
		end
		if (hsel && htrans[1] && hready && !hwrite)
		begin
			unique case ({haddr[7:2], 2'b00})
				HECL_REG_STATUS: rdata_next = {24'h000000, 3'b000, str_reg,
					sig_ok, valid_reg, state_reg != HECL_IDLE, 1'b0};
				HECL_REG_CTRL: rdata_next = {29'h00000000, oc_en_reg, force_def_reg, 1'b0};
				HECL_REG_IDS: rdata_next = {pid_reg, vid_reg};
				HECL_REG_DEV: rdata_next = {7'h00, oc_q_reg, pg_reg, oc_reg, did_reg};
				HECL_REG_POWER: rdata_next = {hchs_reg, hcfs_reg, mphs_reg, mpfs_reg};
				HECL_REG_STRINGS: rdata_next = {2'b00, ptr_stride, 2'b00, ptr_base, lang_reg};
				default: rdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			ph_wr_reg <= 1'b0;
			ph_rd_reg <= 1'b0;
			ph_addr_reg <= 8'h00;
			rdata_reg <= 32'h00000000;
			boot_reg <= 1'b1;
			force_def_reg <= 1'b0;
			oc_en_reg <= 1'b1;
		end
		else
		begin
			ph_wr_reg <= ph_wr_next;
			ph_rd_reg <= ph_rd_next;
			ph_addr_reg <= ph_addr_next;
			rdata_reg <= rdata_next;
			boot_reg <= boot_next;
			force_def_reg <= force_def_next;
			oc_en_reg <= oc_en_next;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_reg;

	// decoded configuration outputs
	assign oc_qualified = oc_q_reg;
	assign config_valid = valid_reg;
	assign vendor_id = vid_reg;
	assign product_id = pid_reg;
	assign release_id_hi = did_reg;
	assign enabled_port_oc_filter_ms = oc_reg[7:4];
	assign disabled_port_oc_filter_ms = oc_reg[3:0];
	assign upstream_current_budget_fs = mpfs_reg;
	assign upstream_current_budget_hs = mphs_reg;
	assign controller_current_draw_fs = hcfs_reg;
	assign controller_current_draw_hs = hchs_reg;
	assign port_power_good_delay = pg_reg;
	assign language_count = lang_reg;
	assign strings_enabled = str_reg;
endmodule // hecl_loader

// File: verilog/hecl_pkg.sv
// package: constants shared by the configuration loader files
package hecl_pkg;
	// image byte offsets
	localparam logic [4:0] HECL_OFS_SIG = 5'h00;
	localparam logic [4:0] HECL_OFS_VID_LO = 5'h01;
	localparam logic [4:0] HECL_OFS_VID_HI = 5'h02;
	localparam logic [4:0] HECL_OFS_PID_LO = 5'h03;
	localparam logic [4:0] HECL_OFS_PID_HI = 5'h04;
	localparam logic [4:0] HECL_OFS_DID_HI = 5'h06;
	localparam logic [4:0] HECL_OFS_OC = 5'h07;
	localparam logic [4:0] HECL_OFS_MP_FS = 5'h08;
	localparam logic [4:0] HECL_OFS_MP_HS = 5'h09;
	localparam logic [4:0] HECL_OFS_HC_FS = 5'h0c;
	localparam logic [4:0] HECL_OFS_HC_HS = 5'h0d;
	localparam logic [4:0] HECL_OFS_PG = 5'h10;
	localparam logic [4:0] HECL_OFS_LANG = 5'h14;
	localparam logic [4:0] HECL_LOAD_BYTES = 5'h15;
	localparam logic [9:0] HECL_LANG_ARRAY = 10'h018;
	localparam logic [7:0] HECL_MAX_LANGS = 8'h1f;
	// fall-back values
	localparam logic [7:0] HECL_DEF_OC = 8'h88;
	localparam logic [7:0] HECL_DEF_MP_FS = 8'h28;
	localparam logic [7:0] HECL_DEF_MP_HS = 8'h57;
	localparam logic [7:0] HECL_DEF_HC_FS = 8'h50;
	localparam logic [7:0] HECL_DEF_HC_HS = 8'hae;
	localparam logic [7:0] HECL_DEF_PG = 8'h32;
	localparam logic [7:0] HECL_DEF_LANG = 8'h00;
	// identity codes: arbitrary neutral values
	localparam logic [7:0] HECL_SIGNATURE = 8'h5a;
	localparam logic [15:0] HECL_DEF_VID = 16'h1234;
	localparam logic [15:0] HECL_DEF_PID = 16'h5678;
	localparam logic [7:0] HECL_DEF_DID_HI = 8'h01;
	// serial memory
	localparam logic [7:0] HECL_CMD_READ = 8'h03;
	localparam logic [15:0] HECL_START_ADDR = 16'h0000;
	// timing
	localparam int HECL_CLK_PERIOD_NS = 10;
	localparam int HECL_MS_NS = 1000000;
	localparam int HECL_MS_CYCLES = HECL_MS_NS / HECL_CLK_PERIOD_NS;
	localparam int HECL_SPI_HALF_NS = 50;
	localparam int HECL_SPI_HALF_CYCLES = (HECL_SPI_HALF_NS + HECL_CLK_PERIOD_NS - 1)
		/ HECL_CLK_PERIOD_NS;
	// register byte addresses
	localparam logic [7:0] HECL_REG_STATUS = 8'h00;
	localparam logic [7:0] HECL_REG_CTRL = 8'h04;
	localparam logic [7:0] HECL_REG_IDS = 8'h08;
	localparam logic [7:0] HECL_REG_DEV = 8'h0c;
	localparam logic [7:0] HECL_REG_POWER = 8'h10;
	localparam logic [7:0] HECL_REG_STRINGS = 8'h14;
	// control bits
	localparam int HECL_CTRL_RELOAD = 0;
	localparam int HECL_CTRL_FORCE_DEF = 1;
	localparam int HECL_CTRL_OC_EN = 2;
	// loader states
	typedef enum logic [2:0]
	{
		HECL_IDLE = 3'b000,
		HECL_CMD = 3'b001,
		HECL_ADDR_HI = 3'b010,
		HECL_ADDR_LO = 3'b011,
		HECL_READ = 3'b100,
		HECL_DONE = 3'b101
	} hecl_state_type;
endpackage

// File: verilog/hecl_spi_byte.sv
// module: one-byte mode-0 serial shifter with its own clock divider
`timescale 1ns/1ps
module hecl_spi_byte #(
	parameter int HALF_CYCLES = 5
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [7:0] tx_byte,
	input wire logic miso,
	output logic sck,
	output logic mosi,
	output logic busy,
	output logic done,
	output logic [7:0] rx_byte
);
	// refused at elaboration: a zero half period would wrap the tick compare to 65535
	if (HALF_CYCLES < 1)
	begin : g_bad_half
		$error("half period must be at least one cycle");
	end

	logic [15:0] div_reg, div_next;
	logic [4:0] edge_reg, edge_next;
	logic [7:0] shift_reg, shift_next;
	logic [7:0] rx_reg, rx_next;
	logic busy_reg, busy_next;
	logic sck_reg, sck_next;
	logic done_reg, done_next;
	logic tick;

	// sixteen sck half periods per byte, data changes while sck is low
	assign tick = (div_reg == 16'(HALF_CYCLES - 1));

	always_comb
	begin
		div_next = div_reg;
		edge_next = edge_reg;
		shift_next = shift_reg;
		rx_next = rx_reg;
		busy_next = busy_reg;
		sck_next = sck_reg;
		done_next = 1'b0;
		if (!busy_reg)
		begin
			if (start)
			begin
				busy_next = 1'b1;
				shift_next = tx_byte;
				div_next = 16'h0000;
				edge_next = 5'h00;
			end
		end
		else if (tick)
		begin
			div_next = 16'h0000;
			sck_next = ~sck_reg;
			edge_next = edge_reg + 5'h01;
			if (!sck_reg)
				rx_next = {rx_reg[6:0], miso}; // sample on rising edge
			else
				shift_next = {shift_reg[6:0], 1'b0}; // advance on falling edge
			if (edge_reg == 5'h0f)
			begin
				busy_next = 1'b0;
				done_next = 1'b1;
			end
		end
		else
			div_next = div_reg + 16'h0001;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			div_reg <= 16'h0000;
			edge_reg <= 5'h00;
			shift_reg <= 8'h00;
			rx_reg <= 8'h00;
			busy_reg <= 1'b0;
			sck_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else
		begin
			div_reg <= div_next;
			edge_reg <= edge_next;
			shift_reg <= shift_next;
			rx_reg <= rx_next;
			busy_reg <= busy_next;
			sck_reg <= sck_next;
			done_reg <= done_next;
		end
	end

	assign sck = sck_reg;
	assign mosi = shift_reg[7];
	assign busy = busy_reg;
	assign done = done_reg;
	assign rx_byte = rx_reg;
endmodule // hecl_spi_byte
